// File: design/bridge_sensor_measurement_sequencer.sv
// Notes on behaviour
// RULE1: thirteen gains 420 down to 2.8, each a fixed three-stage combination.
// RULE2: six-bit zero shift field gives signed steps up to magnitude 31.
// RULE3: zero-shift step size follows the second-stage gain in use.
// RULE4: bridge readings get digital offset correction using the channel offset sample.
// RULE5: multiplexer steps temperature, channel offset, then bridge in fixed order.
// RULE6: bridge measurements per cycle configurable from 1 through 31.
// RULE7: startup routine gets first valid output before the repeating cycle.
// RULE8: startup routine takes about five conversion periods.
// RULE9: common-mode and both short checks are measured in every cycle.
// RULE10: resolution 13 or 14 bits, or 15 or 16 with segmentation.
// RULE11: converter runs first-order or second-order.
// RULE12: first-order conversion lasts 2^r half-rate clock periods.
// RULE13: second-order conversion lasts 2^((r+3)/2) half-rate clock periods.
// RULE14: result is 2^r times input ratio plus selectable range shift.
// RULE15: reference is bridge top to bottom, analog supply when select is 1.
// RULE16: no internal check that input stays within 10% to 90% of range.
// RULE17: user picks resolution one bit above needed output, more if under half used.
// RULE18: configuration is loaded from nonvolatile memory before startup begins.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
module bridge_sensor_measurement_sequencer #(
  parameter int TIME_SHIFT = 0
) (
  input wire logic core_clk, // 10 MHz oscillator clock
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic nvm_req, // asks for the configuration image
  input wire logic nvm_valid, // image on nvm_cfg is valid
  input wire sequencer_pkg::cfg_t nvm_cfg, // configuration image
  input wire logic [15:0] adc_ratio, // analog input over reference
  output sequencer_pkg::afe_t afe, // front end settings
  output sequencer_pkg::mux_sel_t mux_sel, // multiplexer input
  output logic conv_start, // conversion start pulse
  output logic result_valid, // corrected bridge value updated
  output logic [18:0] bridge_corr, // offset corrected bridge count
  output logic startup_done // first valid output available
);

  sequencer_pkg::seq_state_t state_r;
  sequencer_pkg::cfg_t cfg_r;
  sequencer_pkg::mux_sel_t mux_nxt;
  logic [31:0] ctrl_r;
  logic run;
  logic startup_r;
  logic [5:0] step_r;
  logic [5:0] n_bridge;
  logic last_step;
  logic [7:0] cycle_cnt_r;
  logic conv_busy;
  logic conv_done;
  logic [17:0] conv_count;
  logic [17:0] bridge_r;
  logic [17:0] offset_r;
  logic [17:0] temp_r;
  logic [17:0] cmode_r;
  logic [17:0] short_pos_r;
  logic [17:0] short_neg_r;
  logic [31:0] rdata;
  logic addr_ok;
  logic wr_access;

  assign run = ctrl_r[sequencer_pkg::CTRL_RUN_BIT];

  // bridge count, zero read as one
  always_comb begin
    if (cfg_r.bridge_cnt < sequencer_pkg::BRIDGE_MIN) begin
      n_bridge = {1'b0, sequencer_pkg::BRIDGE_MIN}; // see RULE6
    end else begin
      n_bridge = {1'b0, cfg_r.bridge_cnt}; // see RULE6
    end
  end

  // multiplexer choice for the current step
  always_comb begin
    mux_nxt = sequencer_pkg::MUX_IDLE;
    last_step = 1'b0;
    if (startup_r) begin
      // temp, offset, bridge, offset, bridge: five conversions
      last_step = (step_r == {3'h0, sequencer_pkg::STARTUP_LAST}); // see RULE8
      case (step_r)
        6'h00: mux_nxt = sequencer_pkg::MUX_TEMP; // see RULE7
        6'h01: mux_nxt = sequencer_pkg::MUX_OFFSET;
        6'h02: mux_nxt = sequencer_pkg::MUX_BRIDGE;
        6'h03: mux_nxt = sequencer_pkg::MUX_OFFSET;
        default: mux_nxt = sequencer_pkg::MUX_BRIDGE;
      endcase
    end else begin
      last_step = (step_r == n_bridge + 6'h04);
      if (step_r == 6'h00) begin
        mux_nxt = sequencer_pkg::MUX_TEMP; // see RULE5
      end else if (step_r == 6'h01) begin
        mux_nxt = sequencer_pkg::MUX_OFFSET; // see RULE5
      end else if (step_r <= n_bridge + 6'h01) begin
        mux_nxt = sequencer_pkg::MUX_BRIDGE; // see RULE5
      end else if (step_r == n_bridge + 6'h02) begin
        mux_nxt = sequencer_pkg::MUX_CMODE; // see RULE9
      end else if (step_r == n_bridge + 6'h03) begin
        mux_nxt = sequencer_pkg::MUX_SHORT_POS; // see RULE9
      end else begin
        mux_nxt = sequencer_pkg::MUX_SHORT_NEG; // see RULE9
      end
    end
  end

  // sequencer state, step pointer and phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= sequencer_pkg::ST_IDLE;
      step_r <= 6'h00;
      startup_r <= 1'b1;
    end else begin
      case (state_r)
        sequencer_pkg::ST_IDLE: begin
          step_r <= 6'h00;
          startup_r <= 1'b1;
          if (run) begin
            state_r <= sequencer_pkg::ST_LOAD;
          end
        end
        sequencer_pkg::ST_LOAD: begin
          if (!run) begin
            state_r <= sequencer_pkg::ST_IDLE;
          end else if (nvm_valid) begin
            state_r <= sequencer_pkg::ST_LAUNCH; // see RULE18
          end
        end
        sequencer_pkg::ST_LAUNCH: begin
          state_r <= sequencer_pkg::ST_CONV;
        end
        sequencer_pkg::ST_CONV: begin
          if (conv_done) begin
            if (last_step) begin
              step_r <= 6'h00;
              startup_r <= 1'b0; // see RULE7
            end else begin
              step_r <= step_r + 6'h01;
            end
            if (run) begin
              state_r <= sequencer_pkg::ST_LAUNCH;
            end else begin
              state_r <= sequencer_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= sequencer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // configuration fetch request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_req <= 1'b0;
    end else begin
      nvm_req <= run && (state_r == sequencer_pkg::ST_LOAD) && !nvm_valid; // see RULE18
    end
  end

  // active configuration, taken from the image before startup
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= '0;
    end else if (state_r == sequencer_pkg::ST_LOAD && run && nvm_valid) begin
      cfg_r <= nvm_cfg; // see RULE18
    end
  end

  // gain decode into the three stage gains, stage three fixed at 2
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      afe <= '0;
    end else begin
      case (cfg_r.gain_idx) // see RULE1
        4'h0: begin afe.amp1 <= sequencer_pkg::AMP1_30; afe.amp2 <= sequencer_pkg::AMP2_7; end
        4'h1: begin afe.amp1 <= sequencer_pkg::AMP1_30; afe.amp2 <= sequencer_pkg::AMP2_4P66; end
        4'h2: begin afe.amp1 <= sequencer_pkg::AMP1_15; afe.amp2 <= sequencer_pkg::AMP2_7; end
        4'h3: begin afe.amp1 <= sequencer_pkg::AMP1_15; afe.amp2 <= sequencer_pkg::AMP2_4P66; end
        4'h4: begin afe.amp1 <= sequencer_pkg::AMP1_7P5; afe.amp2 <= sequencer_pkg::AMP2_7; end
        4'h5: begin afe.amp1 <= sequencer_pkg::AMP1_7P5; afe.amp2 <= sequencer_pkg::AMP2_4P66; end
        4'h6: begin afe.amp1 <= sequencer_pkg::AMP1_3P75; afe.amp2 <= sequencer_pkg::AMP2_7; end
        4'h7: begin afe.amp1 <= sequencer_pkg::AMP1_3P75; afe.amp2 <= sequencer_pkg::AMP2_4P66; end
        4'h8: begin afe.amp1 <= sequencer_pkg::AMP1_3P75; afe.amp2 <= sequencer_pkg::AMP2_3P5; end
        4'h9: begin afe.amp1 <= sequencer_pkg::AMP1_1; afe.amp2 <= sequencer_pkg::AMP2_7; end
        4'hA: begin afe.amp1 <= sequencer_pkg::AMP1_1; afe.amp2 <= sequencer_pkg::AMP2_4P66; end
        4'hB: begin afe.amp1 <= sequencer_pkg::AMP1_1; afe.amp2 <= sequencer_pkg::AMP2_3P5; end
        default: begin afe.amp1 <= sequencer_pkg::AMP1_1; afe.amp2 <= sequencer_pkg::AMP2_1P4; end
      endcase
      afe.zs_step <= sequencer_pkg::AMP2_7;
      case (cfg_r.gain_idx) // see RULE3
        4'h8, 4'hB: afe.zs_step <= sequencer_pkg::AMP2_3P5;
        4'h1, 4'h3, 4'h5, 4'h7, 4'hA: afe.zs_step <= sequencer_pkg::AMP2_4P66;
        4'h0, 4'h2, 4'h4, 4'h6, 4'h9: afe.zs_step <= sequencer_pkg::AMP2_7;
        default: afe.zs_step <= sequencer_pkg::AMP2_1P4;
      endcase
      afe.zs_neg <= cfg_r.zs_neg && (cfg_r.zs_mag != 5'h00); // see RULE2
      afe.zs_mag <= cfg_r.zs_mag; // see RULE2
      afe.ref_sel <= cfg_r.ref_sel; // see RULE15
      afe.temp_src <= cfg_r.temp_src; // see RULE5
    end
  end

  // multiplexer and start pulse for the next conversion
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_sel <= sequencer_pkg::MUX_IDLE;
      conv_start <= 1'b0;
    end else begin
      conv_start <= (state_r == sequencer_pkg::ST_LAUNCH);
      if (state_r == sequencer_pkg::ST_LAUNCH) begin
        mux_sel <= mux_nxt;
      end else if (state_r == sequencer_pkg::ST_IDLE) begin
        mux_sel <= sequencer_pkg::MUX_IDLE;
      end
    end
  end

  // converter timing and scaling; no check of the 10..90% input window
  conv_engine #(
    .TIME_SHIFT(TIME_SHIFT)
  ) u_conv (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(conv_start),
    .res_sel(cfg_r.res_sel), // see RULE10
    .second_order(cfg_r.second_order), // see RULE11
    .rs_sel(cfg_r.rs_sel),
    .ratio(adc_ratio), // see RULE16
    .busy(conv_busy),
    .done(conv_done),
    .count(conv_count)
  );

  // sort finished counts by the channel that was measured
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bridge_r <= 18'h00000;
      offset_r <= 18'h00000;
      temp_r <= 18'h00000;
      cmode_r <= 18'h00000;
      short_pos_r <= 18'h00000;
      short_neg_r <= 18'h00000;
    end else if (conv_done) begin
      case (mux_sel)
        sequencer_pkg::MUX_TEMP: temp_r <= conv_count;
        sequencer_pkg::MUX_OFFSET: offset_r <= conv_count;
        sequencer_pkg::MUX_BRIDGE: bridge_r <= conv_count;
        sequencer_pkg::MUX_CMODE: cmode_r <= conv_count;
        sequencer_pkg::MUX_SHORT_POS: short_pos_r <= conv_count;
        sequencer_pkg::MUX_SHORT_NEG: short_neg_r <= conv_count;
        default: temp_r <= temp_r;
      endcase
    end
  end

  // digital offset correction of each bridge reading
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bridge_corr <= 19'h00000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (conv_done && mux_sel == sequencer_pkg::MUX_BRIDGE) begin
        bridge_corr <= {1'b0, conv_count} - {1'b0, offset_r}; // see RULE4
        result_valid <= 1'b1;
      end
    end
  end

  // first output flag and normal cycle counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_done <= 1'b0;
      cycle_cnt_r <= 8'h00;
    end else if (state_r == sequencer_pkg::ST_IDLE) begin
      startup_done <= 1'b0;
      cycle_cnt_r <= 8'h00;
    end else if (state_r == sequencer_pkg::ST_CONV && conv_done && last_step) begin
      if (startup_r) begin
        startup_done <= 1'b1; // see RULE7
      end else begin
        cycle_cnt_r <= cycle_cnt_r + 8'h01;
      end
    end
  end

  // apb read mux and address decode
  always_comb begin
    rdata = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      sequencer_pkg::ADDR_CTRL: rdata = ctrl_r;
      sequencer_pkg::ADDR_STATUS: begin
        rdata[sequencer_pkg::STAT_STATE_LSB +: 2] = state_r;
        rdata[sequencer_pkg::STAT_MUX_LSB +: 3] = mux_sel;
        rdata[sequencer_pkg::STAT_READY_BIT] = startup_done;
        rdata[sequencer_pkg::STAT_BUSY_BIT] = conv_busy;
        rdata[sequencer_pkg::STAT_CYCLE_LSB +: 8] = cycle_cnt_r;
        rdata[sequencer_pkg::STAT_STEP_LSB +: 6] = step_r;
      end
      sequencer_pkg::ADDR_CFG: rdata = {9'h000, cfg_r};
      sequencer_pkg::ADDR_BRIDGE: rdata = {14'h0000, bridge_r};
      sequencer_pkg::ADDR_CORR: rdata = {{13{bridge_corr[18]}}, bridge_corr};
      sequencer_pkg::ADDR_TEMP: rdata = {14'h0000, temp_r};
      sequencer_pkg::ADDR_CMODE: rdata = {14'h0000, cmode_r};
      sequencer_pkg::ADDR_SHORT_POS: rdata = {14'h0000, short_pos_r};
      sequencer_pkg::ADDR_SHORT_NEG: rdata = {14'h0000, short_neg_r};
      sequencer_pkg::ADDR_OFFSET: rdata = {14'h0000, offset_r};
      default: addr_ok = 1'b0;
    endcase
  end

  assign wr_access = psel && penable && pready && pwrite;

  // apb slave: answer prepared in setup, ready in the access cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // control register, only the run bit is writable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= sequencer_pkg::CTRL_RESET;
    end else if (wr_access && paddr == sequencer_pkg::ADDR_CTRL) begin
      ctrl_r[sequencer_pkg::CTRL_RUN_BIT] <= pwdata[sequencer_pkg::CTRL_RUN_BIT];
    end
  end

endmodule

// File: design/sequencer_pkg.sv
package sequencer_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_BRIDGE = 8'h0C;
  localparam logic [7:0] ADDR_CORR = 8'h10;
  localparam logic [7:0] ADDR_TEMP = 8'h14;
  localparam logic [7:0] ADDR_CMODE = 8'h18;
  localparam logic [7:0] ADDR_SHORT_POS = 8'h1C;
  localparam logic [7:0] ADDR_SHORT_NEG = 8'h20;
  localparam logic [7:0] ADDR_OFFSET = 8'h24;

  // control register layout and reset
  localparam int CTRL_RUN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MUX_LSB = 2;
  localparam int STAT_READY_BIT = 5;
  localparam int STAT_BUSY_BIT = 6;
  localparam int STAT_CYCLE_LSB = 8;
  localparam int STAT_STEP_LSB = 16;

  // configuration limits
  localparam logic [3:0] GAIN_LAST = 4'hC;
  localparam logic [4:0] BRIDGE_MIN = 5'h01;
  localparam logic [2:0] STARTUP_LAST = 3'h4;

  // converter timing, in ticks of the half-rate clock
  localparam logic [16:0] CONV1_LEN_13 = 17'h02000;
  localparam logic [16:0] CONV2_LEN_13 = 17'h00100;
  localparam logic [16:0] CONV2_LEN_14 = 17'h0016A;
  localparam logic [16:0] CONV2_LEN_15 = 17'h00200;
  localparam logic [16:0] CONV2_LEN_16 = 17'h002D4;

  // range shift as a fraction with 16 fractional bits
  localparam logic [17:0] RS_1_16 = 18'h01000;
  localparam logic [17:0] RS_1_8 = 18'h02000;
  localparam logic [17:0] RS_1_4 = 18'h04000;
  localparam logic [17:0] RS_1_2 = 18'h08000;
  localparam logic [1:0] RES_SHIFT_13 = 2'h3;

  typedef enum logic [2:0] {
    AMP1_30 = 3'b000, AMP1_15 = 3'b001, AMP1_7P5 = 3'b010,
    AMP1_3P75 = 3'b011, AMP1_1 = 3'b100
  } amp1_t;

  // second stage gain; its code also picks the zero-shift step size
  typedef enum logic [1:0] {
    AMP2_7 = 2'b00, AMP2_4P66 = 2'b01, AMP2_3P5 = 2'b10, AMP2_1P4 = 2'b11
  } amp2_t;

  typedef enum logic [1:0] {
    TS_EXT_DIODE = 2'b00, TS_INTERNAL = 2'b01, TS_BRIDGE = 2'b10, TS_THERMISTOR = 2'b11
  } temp_src_t;

  typedef enum logic [2:0] {
    MUX_IDLE = 3'b000, MUX_TEMP = 3'b001, MUX_OFFSET = 3'b010, MUX_BRIDGE = 3'b011,
    MUX_CMODE = 3'b100, MUX_SHORT_POS = 3'b101, MUX_SHORT_NEG = 3'b110
  } mux_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_LOAD = 2'b01, ST_LAUNCH = 2'b10, ST_CONV = 2'b11
  } seq_state_t;

  // nonvolatile configuration image
  typedef struct packed {
    temp_src_t temp_src;
    logic ref_sel;
    logic [1:0] rs_sel;
    logic second_order;
    logic [1:0] res_sel;
    logic [4:0] bridge_cnt;
    logic zs_neg;
    logic [4:0] zs_mag;
    logic [3:0] gain_idx;
  } cfg_t;

  // settings driven into the analog front end
  typedef struct packed {
    amp1_t amp1;
    amp2_t amp2;
    amp2_t zs_step;
    logic zs_neg;
    logic [4:0] zs_mag;
    logic ref_sel;
    temp_src_t temp_src;
  } afe_t;

endpackage

// File: design/conv_engine.sv
// times one conversion on the half-rate clock and scales the sampled ratio
module conv_engine #(
  parameter int TIME_SHIFT = 0
) (
  input wire logic core_clk, // oscillator clock
  input wire logic arst_n, // async reset, active low
  input wire logic start, // one-cycle start pulse
  input wire logic [1:0] res_sel, // resolution minus 13
  input wire logic second_order, // stacked conversion mode
  input wire logic [1:0] rs_sel, // range shift select
  input wire logic [15:0] ratio, // input over reference, 16 fraction bits
  output logic busy, // conversion running
  output logic done, // one-cycle end pulse
  output logic [17:0] count // conversion result
);

  logic [16:0] len;
  logic [16:0] len_s;
  logic [17:0] rs;
  logic [17:0] sum;
  logic half_r;
  logic [16:0] cnt_r;

  // conversion length by order and resolution
  always_comb begin
    if (second_order) begin
      case (res_sel) // see RULE13
        2'h0: len = sequencer_pkg::CONV2_LEN_13;
        2'h1: len = sequencer_pkg::CONV2_LEN_14;
        2'h2: len = sequencer_pkg::CONV2_LEN_15;
        default: len = sequencer_pkg::CONV2_LEN_16;
      endcase
    end else begin
      len = sequencer_pkg::CONV1_LEN_13 << res_sel; // see RULE12
    end
    len_s = len >> TIME_SHIFT;
    if (len_s == 17'h00000) begin
      len_s = 17'h00001;
    end
  end

  // range shift and scaling to 2^r counts
  always_comb begin
    case (rs_sel) // see RULE14
      2'h0: rs = sequencer_pkg::RS_1_16;
      2'h1: rs = sequencer_pkg::RS_1_8;
      2'h2: rs = sequencer_pkg::RS_1_4;
      default: rs = sequencer_pkg::RS_1_2;
    endcase
    sum = {2'h0, ratio} + rs;
  end

  // half-rate tick counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      half_r <= 1'b0;
      cnt_r <= 17'h00000;
      done <= 1'b0;
      count <= 18'h00000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        half_r <= 1'b0;
        cnt_r <= 17'h00000;
      end else if (busy) begin
        half_r <= ~half_r;
        if (half_r) begin
          if (cnt_r == len_s - 17'h00001) begin
            busy <= 1'b0;
            done <= 1'b1;
            count <= sum >> (sequencer_pkg::RES_SHIFT_13 - res_sel); // see RULE14
          end else begin
            cnt_r <= cnt_r + 17'h00001;
          end
        end
      end
    end
  end

endmodule

// File: sim/front_end_model.sv
// configuration memory and analog path
module front_end_model (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic nvm_req, // image request
  input wire sequencer_pkg::cfg_t cfg_in, // image to serve
  input wire sequencer_pkg::mux_sel_t mux_sel, // channel converted
  output logic nvm_valid, // image valid
  output sequencer_pkg::cfg_t nvm_cfg, // image lines
  output logic [15:0] adc_ratio // input over reference
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  // memory answers after a few cycles, holds until released
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 2'h0;
      nvm_valid <= 1'h0;
    end else if (!nvm_req) begin
      wait_r <= 2'h0;
      nvm_valid <= 1'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
      nvm_valid <= (wait_r == 2'h3) | nvm_valid;
    end
  end
  // lines show the inverse outside a valid image
  assign nvm_cfg = nvm_valid ? cfg_in : ~cfg_in;
  // ratio per channel, never range checked
  assign adc_ratio = {1'h0, mux_sel, 12'h400};
endmodule

// File: sim/bridge_sensor_measurement_sequencer_properties.sv
// port level bus and sequencing checks
module bridge_sensor_measurement_sequencer_properties (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic nvm_req, // image request
  input wire logic nvm_valid, // image valid
  input wire sequencer_pkg::afe_t afe, // front end settings
  input wire sequencer_pkg::mux_sel_t mux_sel, // multiplexer input
  input wire logic conv_start, // start pulse
  input wire logic result_valid, // result pulse
  input wire logic [18:0] bridge_corr // corrected value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // bus setup cycle and a launched conversion
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence conv_launch;
    conv_start && mux_sel != sequencer_pkg::MUX_IDLE;
  endsequence
  zero_wait_a: assert property (apb_setup |=> pready) else $error("no ready after setup");
  access_only_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  req_hold_a: assert property (nvm_req && !nvm_valid |=> nvm_req) else $error("request dropped");
  load_first_a: assert property (nvm_req |-> mux_sel == sequencer_pkg::MUX_IDLE && !conv_start)
    else $error("conversion before load");
  start_pulse_a: assert property (conv_start |-> conv_launch ##1 (!conv_start && $stable(mux_sel)))
    else $error("bad launch");
  result_pulse_a: assert property (result_valid |=> !result_valid) else $error("long result");
  corr_update_a: assert property ($changed(bridge_corr) |-> result_valid)
    else $error("value moved silently");
  step_code_a: assert property (afe.zs_step == afe.amp2)
    else $error("step size mismatch");
  gain_pair_a: assert property (afe.amp2 == sequencer_pkg::AMP2_1P4 |-> afe.amp1 == sequencer_pkg::AMP1_1)
    else $error("bad gain combination");
endmodule
bind bridge_sensor_measurement_sequencer bridge_sensor_measurement_sequencer_properties chk (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .nvm_req(nvm_req), .nvm_valid(nvm_valid), .afe(afe), .mux_sel(mux_sel),
  .conv_start(conv_start), .result_valid(result_valid), .bridge_corr(bridge_corr));

// File: sim/bridge_sensor_measurement_sequencer_test.sv
module bridge_sensor_measurement_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [51:0] AMP1_TBL = 52'h4_4443_3322_1100;
  localparam logic [51:0] AMP2_TBL = 52'h3_2102_1010_1010;
  localparam logic [47:0] SEQ_TBL = 48'h6543_3213_2321;
  localparam logic [15:0] LSEC_TBL = 16'h2211;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, nvm_req, nvm_valid;
  logic conv_start, result_valid, startup_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] adc_ratio;
  logic [18:0] bridge_corr, last_corr;
  sequencer_pkg::cfg_t cfg, nvm_cfg;
  sequencer_pkg::afe_t afe;
  sequencer_pkg::mux_sel_t mux_sel;
  int err_total = 0, checks = 0, cyc = 0;
  int t_q[$];
  logic [2:0] seq_q[$];
  bridge_sensor_measurement_sequencer #(.TIME_SHIFT(8)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_req(nvm_req),
    .nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg), .adc_ratio(adc_ratio), .afe(afe),
    .mux_sel(mux_sel), .conv_start(conv_start), .result_valid(result_valid),
    .bridge_corr(bridge_corr), .startup_done(startup_done));
  front_end_model fe (.core_clk(core_clk), .arst_n(arst_n), .nvm_req(nvm_req), .cfg_in(cfg),
    .mux_sel(mux_sel), .nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg), .adc_ratio(adc_ratio));
  // clock at 10 MHz
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // logs each launch and the last corrected value
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'h1) begin
      seq_q.push_back(mux_sel);
      t_q.push_back(cyc);
    end
    if (result_valid === 1'h1) last_corr <= bridge_corr;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'h0, a, 32'h0, q, e);
  endtask
  task automatic wait_q(input int k);
    int n = 0;
    while (seq_q.size() < k && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 2000) err_total++;
  endtask
  // stop, reload an image and wait for the first launch
  task automatic restart(input sequencer_pkg::cfg_t c);
    logic [31:0] q;
    logic e;
    int n = 0;
    apb(1'h1, sequencer_pkg::ADDR_CTRL, 32'h0, q, e);
    do begin
      rd(sequencer_pkg::ADDR_STATUS, q);
      n++;
    end while (q[1:0] !== sequencer_pkg::ST_IDLE && n < 200);
    if (n == 200) err_total++;
    cfg <= c;
    seq_q.delete();
    t_q.delete();
    apb(1'h1, sequencer_pkg::ADDR_CTRL, 32'h1, q, e);
    wait_q(1);
  endtask
  task t_regs;
    logic [31:0] q;
    logic e;
    rd(sequencer_pkg::ADDR_CTRL, q);
    check(q, 32'h0);
    apb(1'h0, 8'h3C, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    apb(1'h1, sequencer_pkg::ADDR_BRIDGE, 32'hFFFF_FFFF, q, e);
    rd(sequencer_pkg::ADDR_BRIDGE, q);
    check(q, 32'h0);
  endtask
  // each gain with zero shift, reference and temp source
  task t_gains;
    sequencer_pkg::cfg_t c;
    logic [31:0] q;
    for (int i = 0; i < 13; i++) begin
      c = '0;
      c.gain_idx = 4'(i);
      c.zs_mag = 5'(i) + 5'h13;
      c.zs_neg = i[0];
      c.ref_sel = i[1];
      c.temp_src = sequencer_pkg::temp_src_t'(i[1:0]);
      c.second_order = 1'h1;
      restart(c);
      check(32'(afe.amp1), 32'(AMP1_TBL[i*4 +: 3]));
      check(32'(afe.amp2), 32'(AMP2_TBL[i*4 +: 2]));
      check(32'(afe.zs_step), 32'(AMP2_TBL[i*4 +: 2]));
      check(32'({afe.zs_neg, afe.zs_mag}), 32'({c.zs_neg, c.zs_mag}));
      check(32'({afe.ref_sel, afe.temp_src}), 32'({c.ref_sel, c.temp_src}));
      rd(sequencer_pkg::ADDR_CFG, q);
      check(q, 32'(c));
    end
  endtask
  // startup, then a cycle with two bridge samples
  task t_sequence;
    sequencer_pkg::cfg_t c;
    c = '0;
    c.bridge_cnt = 5'h02;
    restart(c);
    check(32'(startup_done), 32'h0);
    wait_q(6);
    check(32'(startup_done), 32'h1);
    wait_q(12);
    for (int k = 0; k < 12; k++) check(32'(seq_q[k]), 32'(SEQ_TBL[k*4 +: 3]));
    check(32'(t_q[1] - t_q[0] >= 64 && t_q[1] - t_q[0] <= 72), 32'h1);
  endtask
  // each resolution and range shift, second order
  task t_results;
    sequencer_pkg::cfg_t c;
    logic [31:0] q, rs;
    int s, l, g;
    for (int r = 0; r < 4; r++) begin
      c = '0;
      c.res_sel = 2'(r);
      c.rs_sel = 2'(r);
      c.second_order = 1'h1;
      s = 3 - r;
      rs = 32'h1000 << r;
      l = int'(LSEC_TBL[r*4 +: 4]);
      restart(c);
      wait_q(6);
      g = t_q[1] - t_q[0];
      check(32'(g >= 2 * l && g <= 2 * l + 8), 32'h1);
      rd(sequencer_pkg::ADDR_BRIDGE, q);
      check(q, (32'h3400 + rs) >> s);
      rd(sequencer_pkg::ADDR_OFFSET, q);
      check(q, (32'h2400 + rs) >> s);
      check(32'(last_corr), 32'h1000 >> s);
    end
  endtask
  // watchdog
  initial begin
    #6000000;
    err_total++;
    print_verdict;
  end
  initial begin
    arst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg = '0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'h1;
    t_regs;
    t_gains;
    t_sequence;
    t_results;
    print_verdict;
  end
endmodule
